// ==== adc_front_consts.svh ====
// Offsets, field positions, reset values and timing counts of the front end
`ifndef ADC_FRONT_CONSTS_SVH
`define ADC_FRONT_CONSTS_SVH
`define ADDR_COMMAND 6'h00
`define ADDR_GPIO_PORT 6'h01
`define ADDR_REVISION 6'h02
`define ADDR_TEST 6'h03
`define ADDR_STATUS 6'h04
`define ADDR_CHECKSUM 6'h05
`define ADDR_SETUP_BASE 3'h5
`define ADDR_MODE_BASE 3'h7
`define ADDR_MODE_READ 6'h38
`define CMD_ZERO_BIT 7
`define CMD_READ_BIT 6
`define GPIO_COMMON_LEVEL 7
`define GPIO_SECOND_LEVEL 6
`define GPIO_COMMON_DIR 5
`define GPIO_SECOND_DIR 4
`define GPIO_READY_ALL 3
`define GPIO_SYNC_EN 0
`define GPIO_WRITE_MASK 8'hf9
`define GPIO_PORT_RST 8'h30
`define TEST_RST 24'h000000
`define MODE_RST 8'h00
`define SETUP_RST 8'h00
`define SETUP_PAIR_HI 6
`define SETUP_PAIR_LO 5
`define SETUP_ENABLE 3
`define RESET_ONES 6'd32
`define CLK_PERIOD_NS 100
`define SCLK_HALF_NS 400
`define SCLK_HALF_CYC (`SCLK_HALF_NS / `CLK_PERIOD_NS)
`define WIDE_BITS 6'd24
`define MID_BITS 6'd16
`define BYTE_BITS 6'd8
`endif

// ==== adc_front_pkg.sv ====
// Types and shared helpers of the serial register front end
`include "adc_front_consts.svh"
package adc_front_pkg;
  typedef enum logic [1:0] {ST_CMD, ST_WRITE, ST_READ} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} host_state_t;

  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_s3;
    logic din_s1, din_s2;
    logic cs_s1, cs_s2;
    logic gpio_s1, gpio_s2;
    dev_state_t state;
    logic [5:0] bit_cnt;
    logic [5:0] ones_cnt;
    logic [5:0] addr;
    logic [23:0] shift;
    logic dout;
    logic [7:0] gpio_port;
    logic [23:0] test;
    logic [7:0] mode;
    logic [2:0] mode_ch;
    logic [7:0][7:0] setup;
    logic mode_write;
    logic full_reset;
    logic ready_n;
    logic [2:0] in_pos;
    logic [2:0] in_neg;
    logic in_diff;
  } dev_regs_t;

  typedef struct packed {
    logic dout_s1, dout_s2;
    host_state_t state;
    logic [2:0] phase;
    logic [5:0] bit_cnt;
    logic [5:0] total;
    logic [31:0] tx;
    logic [23:0] rx;
    logic sclk, din, cs_n;
    logic done, refused;
    logic [23:0] rdata;
  } host_regs_t;

  // Bits moved after the command byte for a given register
  function automatic logic [5:0] reg_width(input logic [5:0] a);
    if (a == `ADDR_TEST || a == 6'h06 || a == 6'h07 ||
        a[5:4] == 2'b01)
      return `WIDE_BITS;
    else if (a == `ADDR_CHECKSUM || a[5:3] == 3'b001)
      return `MID_BITS;
    else
      return `BYTE_BITS;
  endfunction
endpackage

// ==== adc_link_if.sv ====
// Serial link between host controller and converter front end
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic cs_n;
  modport device (input sclk, input din, input cs_n, output dout);
  modport host (output sclk, output din, output cs_n, input dout);
endinterface

// ==== adc_front_device.sv ====
// Converter end: command decode and general register bank on the link
//
// Overview of operation
// - Each transfer opens with a command byte
// - Command bit 6: zero writes, one reads
// - Host keeps command bit 7 zero
// - Command bits 5..0 select the register
// - Low three address bits give channel
// - Mode write applies to addressed channel
// - Back to command wait after each access
// - Thirty-two ones with select low reset all
// - Host keeps data-in low while reading
// - Channel maps to single or paired inputs
// - Port bit 7 drives common pin level
// - Port bit 6 drives or reads second pin
// - Port bit 5 chooses analog or output
// - Port bit 4 sets second pin direction
// - Port bit 3 picks any or all ready
// - Host writes zeros to port bits 2,1
// - Port bit 0 enables the sync function
// - Port resets to 30h plus input level
// - Revision reads revision and generic codes
// - Host never changes the test register
// - Command register is write-only at zero
// - Host reads mode only at 38h
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "adc_front_consts.svh"
module adc_front_device
  import adc_front_pkg::*;
#(
  // Arbitrary values, not any real part's codes
  parameter logic [3:0] REVISION_CODE = 4'h2,
  parameter logic [3:0] GENERIC_CODE = 4'h6
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial link
  adc_link_if.device link,
  // Converter state
  input wire logic [7:0] data_unread_i,
  // General pins
  input wire logic second_gpio_i,
  output logic second_gpio_o,
  output logic second_gpio_oe_o,
  output logic common_pin_o,
  output logic common_pin_oe_o,
  output logic sync_enable_o,
  output logic ready_n_o,
  // Converter control
  output logic [7:0] analog_mode_o,
  output logic [2:0] mode_channel_o,
  output logic mode_write_o,
  output logic [2:0] input_pos_o,
  output logic [2:0] input_neg_o,
  output logic input_diff_o,
  output logic full_reset_o,
  output logic [23:0] test_config_o
);
  import adc_front_pkg::*;

  dev_regs_t r_reg;
  dev_regs_t r_next;

  // Bits that the soft reset returns to their defaults
  function automatic dev_regs_t clear_regs(input dev_regs_t v);
    dev_regs_t o;
    o = v;
    o.state = ST_CMD;
    o.bit_cnt = 6'd0;
    o.ones_cnt = 6'd0;
    o.addr = 6'h00;
    o.shift = 24'h000000;
    o.dout = 1'b0;
    o.gpio_port = `GPIO_PORT_RST;
    o.test = `TEST_RST;
    o.mode = `MODE_RST;
    o.mode_ch = 3'd0;
    o.setup = {8{`SETUP_RST}};
    o.mode_write = 1'b0;
    o.full_reset = 1'b0;
    return o;
  endfunction

  logic rise;
  logic [23:0] din_word;
  logic [5:0] width;
  logic [7:0] gpio_view;
  logic [23:0] rd_val;
  logic [7:0] enabled;
  logic [7:0] cur_setup;

  always_comb begin
    r_next = r_reg;
    rise = r_reg.sclk_s2 & ~r_reg.sclk_s3;
    din_word = {r_reg.shift[22:0], r_reg.din_s2};
    width = reg_width(r_reg.addr);
    rd_val = 24'h000000;
    enabled = 8'h00;
    // Live level of the second pin replaces the stored bit as input
    gpio_view = r_reg.gpio_port;
    if (r_reg.gpio_port[`GPIO_SECOND_DIR]) begin
      gpio_view[`GPIO_SECOND_LEVEL] = r_reg.gpio_s2;
    end

    r_next.sclk_s1 = link.sclk;
    r_next.sclk_s2 = r_reg.sclk_s1;
    r_next.sclk_s3 = r_reg.sclk_s2;
    r_next.din_s1 = link.din;
    r_next.din_s2 = r_reg.din_s1;
    r_next.cs_s1 = link.cs_n;
    r_next.cs_s2 = r_reg.cs_s1;
    r_next.gpio_s1 = second_gpio_i;
    r_next.gpio_s2 = r_reg.gpio_s1;
    r_next.mode_write = 1'b0;
    r_next.full_reset = 1'b0;

    if (r_reg.cs_s2) begin
      // Deselect abandons any partial access
      r_next.state = ST_CMD;
      r_next.bit_cnt = 6'd0;
      r_next.ones_cnt = 6'd0;
    end else if (rise) begin
      r_next.bit_cnt = r_reg.bit_cnt + 6'd1;
      unique case (r_reg.state)
        ST_CMD: begin
          r_next.shift = din_word;
          if (r_reg.bit_cnt == 6'd7) begin
            // Bit 7 is not checked; a stray one is taken as zero
            r_next.addr = din_word[5:0];
            r_next.bit_cnt = 6'd0;
            if (din_word[`CMD_READ_BIT]) begin
              unique case (din_word[5:0])
                `ADDR_GPIO_PORT: rd_val = {16'h0000, gpio_view};
                `ADDR_REVISION:
                  rd_val = {16'h0000, REVISION_CODE, GENERIC_CODE};
                `ADDR_TEST: rd_val = r_reg.test;
                `ADDR_STATUS: rd_val = {16'h0000, data_unread_i};
                `ADDR_MODE_READ: rd_val = {16'h0000, r_reg.mode};
                default: begin
                  if (din_word[5:3] == `ADDR_SETUP_BASE) begin
                    rd_val = {16'h0000, r_reg.setup[din_word[2:0]]};
                  end
                end
              endcase
              // Command register reads as nothing: zero data
              r_next.shift = rd_val << (6'd24 - reg_width(din_word[5:0]));
              r_next.state = ST_READ;
            end else begin
              r_next.state = ST_WRITE;
            end
          end
        end
        ST_WRITE: begin
          r_next.shift = din_word;
          if (r_reg.bit_cnt == width - 6'd1) begin
            r_next.state = ST_CMD;
            r_next.bit_cnt = 6'd0;
            if (r_reg.addr == `ADDR_GPIO_PORT) begin
              r_next.gpio_port = din_word[7:0] & `GPIO_WRITE_MASK;
            end else if (r_reg.addr == `ADDR_TEST) begin
              r_next.test = din_word;
            end else if (r_reg.addr[5:3] == `ADDR_SETUP_BASE) begin
              r_next.setup[r_reg.addr[2:0]] = din_word[7:0];
            end else if (r_reg.addr[5:3] == `ADDR_MODE_BASE) begin
              r_next.mode = din_word[7:0];
              r_next.mode_ch = r_reg.addr[2:0];
              r_next.mode_write = 1'b1;
            end
          end
        end
        ST_READ: begin
          // Next bit goes out after the host has taken this one
          r_next.shift = {r_reg.shift[22:0], 1'b0};
          if (r_reg.bit_cnt == width - 6'd1) begin
            r_next.state = ST_CMD;
            r_next.bit_cnt = 6'd0;
          end
        end
      endcase
      if (r_reg.din_s2) begin
        if (r_reg.ones_cnt == `RESET_ONES - 6'd1) begin
          r_next = clear_regs(r_next);
          r_next.full_reset = 1'b1;
          // Further ones keep the counter saturated, no repeat reset
          r_next.ones_cnt = `RESET_ONES;
        end else if (r_reg.ones_cnt != `RESET_ONES) begin
          r_next.ones_cnt = r_reg.ones_cnt + 6'd1;
        end
      end else begin
        r_next.ones_cnt = 6'd0;
      end
    end
    r_next.dout = r_next.shift[23] & (r_next.state == ST_READ);

    for (int i = 0; i < 8; i++) begin
      enabled[i] = r_next.setup[i][`SETUP_ENABLE];
    end
    if (r_next.gpio_port[`GPIO_READY_ALL]) begin
      r_next.ready_n = ~((|enabled) &
                         (&(data_unread_i | ~enabled)));
    end else begin
      r_next.ready_n = ~(|data_unread_i);
    end

    // Pairing field zero is taken as single-ended against common
    cur_setup = r_next.setup[r_next.mode_ch];
    r_next.in_diff = cur_setup[`SETUP_PAIR_HI] |
                     cur_setup[`SETUP_PAIR_LO];
    if (r_next.in_diff) begin
      r_next.in_pos = {r_next.mode_ch[1:0], 1'b0};
      r_next.in_neg = {r_next.mode_ch[1:0], 1'b1};
    end else begin
      r_next.in_pos = r_next.mode_ch;
      r_next.in_neg = r_next.mode_ch;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.sclk_s1 <= 1'b1;
      r_reg.sclk_s2 <= 1'b1;
      r_reg.sclk_s3 <= 1'b1;
      r_reg.cs_s1 <= 1'b1;
      r_reg.cs_s2 <= 1'b1;
      r_reg.gpio_port <= `GPIO_PORT_RST;
      r_reg.test <= `TEST_RST;
      r_reg.mode <= `MODE_RST;
      r_reg.setup <= {8{`SETUP_RST}};
      r_reg.state <= ST_CMD;
      r_reg.ready_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.dout = r_reg.dout;
  assign common_pin_o = r_reg.gpio_port[`GPIO_COMMON_LEVEL];
  assign common_pin_oe_o = ~r_reg.gpio_port[`GPIO_COMMON_DIR];
  assign second_gpio_o = r_reg.gpio_port[`GPIO_SECOND_LEVEL];
  assign second_gpio_oe_o = ~r_reg.gpio_port[`GPIO_SECOND_DIR];
  assign sync_enable_o = r_reg.gpio_port[`GPIO_SYNC_EN];
  assign ready_n_o = r_reg.ready_n;
  assign analog_mode_o = r_reg.mode;
  assign mode_channel_o = r_reg.mode_ch;
  assign mode_write_o = r_reg.mode_write;
  assign input_pos_o = r_reg.in_pos;
  assign input_neg_o = r_reg.in_neg;
  assign input_diff_o = r_reg.in_diff;
  assign full_reset_o = r_reg.full_reset;
  assign test_config_o = r_reg.test;
endmodule

// ==== adc_front_host.sv ====
// Host end: runs register accesses and the link reset sequence
`timescale 1ns/1ps
`include "adc_front_consts.svh"
module adc_front_host
  import adc_front_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial link
  adc_link_if.host link,
  // Command port
  input wire logic start_i,
  input wire logic rnw_i,
  input wire logic [5:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic reset_seq_i,
  // Answer port
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic [23:0] rdata_o
);
  import adc_front_pkg::*;

  localparam logic [2:0] HALF = 3'(`SCLK_HALF_CYC);

  host_regs_t r_reg;
  host_regs_t r_next;
  logic [5:0] w;
  logic [23:0] wd;
  logic [5:0] a_eff;

  always_comb begin
    r_next = r_reg;
    r_next.dout_s1 = link.dout;
    r_next.dout_s2 = r_reg.dout_s1;
    r_next.done = 1'b0;
    r_next.refused = 1'b0;
    // Mode aliases are write-only; every mode read goes out as the one address
    a_eff = addr_i;
    if (rnw_i && addr_i[5:3] == `ADDR_MODE_BASE) begin
      a_eff = `ADDR_MODE_READ;
    end
    w = reg_width(a_eff);
    wd = wdata_i;
    if (addr_i == `ADDR_GPIO_PORT) begin
      wd[2:1] = 2'b00;
    end
    unique case (r_reg.state)
      H_IDLE: begin
        r_next.phase = 3'd0;
        r_next.bit_cnt = 6'd0;
        if (reset_seq_i) begin
          r_next.tx = 32'hffffffff;
          r_next.total = `RESET_ONES;
          r_next.cs_n = 1'b0;
          r_next.state = H_RUN;
        end else if (start_i && !rnw_i && addr_i == `ADDR_TEST) begin
          r_next.refused = 1'b1;
          r_next.done = 1'b1;
        end else if (start_i) begin
          // Read data slots carry zeros so no reset can trigger
          r_next.tx = {1'b0, rnw_i, a_eff,
                       rnw_i ? 24'h000000 :
                       (wd << (6'd24 - w))};
          r_next.total = `BYTE_BITS + w;
          r_next.rx = 24'h000000;
          r_next.cs_n = 1'b0;
          r_next.state = H_RUN;
        end
      end
      H_RUN: begin
        r_next.phase = r_reg.phase + 3'd1;
        if (r_reg.phase == 3'd0) begin
          r_next.sclk = 1'b0;
          r_next.din = r_reg.tx[31];
          r_next.tx = {r_reg.tx[30:0], 1'b0};
        end else if (r_reg.phase == HALF) begin
          r_next.sclk = 1'b1;
          r_next.rx = {r_reg.rx[22:0], r_reg.dout_s2};
          r_next.bit_cnt = r_reg.bit_cnt + 6'd1;
          if (r_reg.bit_cnt == r_reg.total - 6'd1) begin
            r_next.state = H_END;
            r_next.phase = 3'd0;
          end
        end
      end
      H_END: begin
        // Idle gap long enough for the far end to see deselect
        r_next.phase = r_reg.phase + 3'd1;
        if (r_reg.phase == HALF) begin
          // Last bit holds a full half period past its rising edge
          r_next.din = 1'b0;
          r_next.cs_n = 1'b1;
        end
        if (r_reg.phase == 3'd7) begin
          r_next.rdata = r_reg.rx;
          r_next.done = 1'b1;
          r_next.state = H_IDLE;
        end
      end
      default: r_next.state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.state <= H_IDLE;
      r_reg.sclk <= 1'b1;
      r_reg.cs_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.sclk = r_reg.sclk;
  assign link.din = r_reg.din;
  assign link.cs_n = r_reg.cs_n;
  assign busy_o = (r_reg.state != H_IDLE);
  assign done_o = r_reg.done;
  assign refused_o = r_reg.refused;
  assign rdata_o = r_reg.rdata;
endmodule

// ==== adc_link_chk.sv ====
// Protocol checks on the serial link between host and converter ends
`timescale 1ns/1ps
module adc_link_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link signals
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic dout_i,
  input wire logic cs_n_i
);
  logic sclk_q;
  logic [5:0] rise_cnt;
  logic all_ones;
  wire rise = sclk_i && !sclk_q && !cs_n_i;
  // Counts one cycle late; cs_n rises well after the last edge
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 1'b1;
      rise_cnt <= 6'h00;
      all_ones <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
      if (cs_n_i) begin
        rise_cnt <= 6'h00;
        all_ones <= 1'b0;
      end else if (rise) begin
        rise_cnt <= rise_cnt + 6'h01;
        if (rise_cnt == 6'h00) begin
          all_ones <= din_i;
        end
      end
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_IDLE_HIGH: assert property (cs_n_i |-> sclk_i)
    else $error("sclk low while deselected");
  AST_HALF_LOW: assert property ($fell(sclk_i) |=> !sclk_i [*3])
    else $error("sclk low phase too short");
  AST_HALF_HIGH: assert property ($rose(sclk_i) |=> sclk_i [*3])
    else $error("sclk high phase too short");
  AST_DIN_HOLD: assert property (
    $rose(sclk_i) && !cs_n_i |=> $stable(din_i) [*3])
    else $error("din moved right after a rising sclk");
  AST_FALL_SEL: assert property ($fell(sclk_i) |-> !cs_n_i)
    else $error("sclk toggled while deselected");
  AST_FRAME_LEN: assert property (
    $rose(cs_n_i) |-> rise_cnt inside {6'd16, 6'd24, 6'd32})
    else $error("frame length is not command plus width");
  AST_RESET_LEN: assert property (
    $rose(cs_n_i) && all_ones |-> rise_cnt == 6'd32)
    else $error("reset frame is not thirty-two clocks");
  AST_RESET_ONES: assert property (rise && all_ones |-> din_i)
    else $error("zero inside reset frame");
  AST_DOUT_SETUP: assert property (
    !sclk_i && !cs_n_i |-> $stable(dout_i))
    else $error("dout changed while sclk low");
  AST_DOUT_IDLE: assert property (
    cs_n_i && $past(cs_n_i, 4) |-> !dout_i)
    else $error("dout not idle outside frames");
  cover property ($rose(cs_n_i) && rise_cnt == 6'd16);
  cover property ($rose(cs_n_i) && rise_cnt == 6'd32 && !all_ones);
  cover property ($rose(cs_n_i) && all_ones);
  cover property ($rose(dout_i));
endmodule

// ==== adc_serial_register_front_end_test.sv ====
// Self-checking bench joining host and converter ends over the link
`timescale 1ns/1ps
module adc_serial_register_front_end_test;
  import adc_front_pkg::*;
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  localparam logic [3:0] GEN = 4'h9; // Arbitrary value
  logic clk_sys_i, rst_i, start_i, rnw_i, reset_seq_i, second_gpio_i;
  logic [5:0] addr_i;
  logic [23:0] wdata_i, rd, test_config_o, rdata_o;
  logic [7:0] data_unread_i, analog_mode_o;
  logic second_gpio_o, second_gpio_oe_o, common_pin_o, common_pin_oe_o;
  logic sync_enable_o, ready_n_o, mode_write_o, input_diff_o, full_reset_o;
  logic busy_o, done_o, refused_o, refd;
  logic [2:0] mode_channel_o, input_pos_o, input_neg_o;
  int mismatches, tests_run, mw_cnt, fr_cnt;
  adc_link_if link ();
  adc_front_device #(.REVISION_CODE(REV), .GENERIC_CODE(GEN))
    adc_front_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .link(link),
    .data_unread_i(data_unread_i), .second_gpio_i(second_gpio_i),
    .second_gpio_o(second_gpio_o), .second_gpio_oe_o(second_gpio_oe_o),
    .common_pin_o(common_pin_o), .common_pin_oe_o(common_pin_oe_o),
    .sync_enable_o(sync_enable_o), .ready_n_o(ready_n_o),
    .analog_mode_o(analog_mode_o), .mode_channel_o(mode_channel_o),
    .mode_write_o(mode_write_o), .input_pos_o(input_pos_o),
    .input_neg_o(input_neg_o), .input_diff_o(input_diff_o),
    .full_reset_o(full_reset_o), .test_config_o(test_config_o));
  adc_front_host adc_front_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(link), .start_i(start_i), .rnw_i(rnw_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .reset_seq_i(reset_seq_i), .busy_o(busy_o),
    .done_o(done_o), .refused_o(refused_o), .rdata_o(rdata_o));
  adc_link_chk adc_link_chk_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .sclk_i(link.sclk), .din_i(link.din), .dout_i(link.dout),
    .cs_n_i(link.cs_n));
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Pulses last one cycle, so they are counted rather than polled
  always @(posedge clk_sys_i) begin
    if (mode_write_o === 1'b1) mw_cnt++;
    if (full_reset_o === 1'b1) fr_cnt++;
  end
  task automatic summarize;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] exp,
                       input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One host request; result is taken at the done pulse
  task automatic xfer(input logic rs, input logic rnw, input logic [5:0] a,
                      input logic [23:0] d);
    bit got;
    logic b0;
    got = 0;
    b0 = 1'b0;
    @(posedge clk_sys_i);
    start_i <= !rs;
    reset_seq_i <= rs;
    rnw_i <= rnw;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    reset_seq_i <= 1'b0;
    for (int n = 0; n < 1000 && !got; n++) begin
      @(negedge clk_sys_i);
      if (n == 0) b0 = busy_o;
      if (done_o === 1'b1) begin
        got = 1;
        rd = rdata_o;
        refd = refused_o;
      end
    end
    if (!got) begin
      mismatches++;
      $display("wrong value done_o expected 1 seen 0");
      summarize();
    end
    // A refused test write never leaves idle
    check("busy_run", rs || rnw || a != 6'h03, b0);
    check("busy_end", 0, busy_o);
  endtask
  task automatic t_defaults;
    xfer(0, 1, 6'h01, 0);
    check("port", 24'h70, rd);
    check("common_oe", 0, common_pin_oe_o);
    check("second_oe", 0, second_gpio_oe_o);
    check("sync", 0, sync_enable_o);
    xfer(0, 1, 6'h02, 0);
    check("revision", {16'h0000, REV, GEN}, rd);
    xfer(0, 1, 6'h00, 0);
    check("command", 0, rd);
    $display("defaults finished");
  endtask
  task automatic t_gpio;
    xfer(0, 0, 6'h01, 24'hc6);
    check("common_oe", 1, common_pin_oe_o);
    check("common_out", 1, common_pin_o);
    check("second_oe", 1, second_gpio_oe_o);
    check("second_out", 1, second_gpio_o);
    @(posedge clk_sys_i);
    second_gpio_i <= 1'b0;
    xfer(0, 1, 6'h01, 0);
    check("port", 24'hc0, rd);
    xfer(0, 0, 6'h01, 24'h39);
    check("second_oe", 0, second_gpio_oe_o);
    check("common_oe", 0, common_pin_oe_o);
    check("sync", 1, sync_enable_o);
    xfer(0, 1, 6'h01, 0);
    check("port", 24'h39, rd);
    @(posedge clk_sys_i);
    second_gpio_i <= 1'b1;
    xfer(0, 1, 6'h01, 0);
    check("port", 24'h79, rd);
    $display("gpio finished");
  endtask
  task automatic t_ready;
    logic [7:0] u[4];
    logic e;
    u = '{8'h01, 8'h03, 8'h04, 8'h00};
    xfer(0, 0, 6'h28, 24'h08);
    xfer(0, 0, 6'h29, 24'h08);
    for (int m = 0; m < 2; m++) begin
      xfer(0, 0, 6'h01, m ? 24'h30 : 24'h38);
      for (int i = 0; i < 4; i++) begin
        @(posedge clk_sys_i);
        data_unread_i <= u[i];
        repeat (4) @(negedge clk_sys_i);
        // Channels 0 and 1 are the only enabled ones
        e = m ? u[i] == 0 : (u[i] & 8'h03) != 8'h03;
        check("ready_n", e, ready_n_o);
        xfer(0, 1, 6'h04, 0);
        check("status", u[i], rd);
      end
    end
    $display("ready finished");
  endtask
  task automatic t_mode;
    logic [2:0] c[4];
    logic d[4];
    logic [2:0] p;
    int w;
    c = '{3'd5, 3'd1, 3'd7, 3'd3};
    // Channels 5 and 3 get a pairing code, 1 and 7 stay single-ended
    d = '{1'b1, 1'b0, 1'b0, 1'b1};
    xfer(0, 0, 6'h2d, 24'h20);
    xfer(0, 0, 6'h2b, 24'h40);
    for (int i = 0; i < 4; i++) begin
      w = mw_cnt;
      p = d[i] ? {c[i][1:0], 1'b0} : c[i];
      xfer(0, 0, {3'b111, c[i]}, {16'h0000, 5'h04, c[i]});
      check("mode_write", 1, mw_cnt - w);
      check("mode", {5'h04, c[i]}, analog_mode_o);
      check("mode_ch", c[i], mode_channel_o);
      check("diff", d[i], input_diff_o);
      check("pos", p, input_pos_o);
      if (d[i]) check("neg", {c[i][1:0], 1'b1}, input_neg_o);
    end
    xfer(0, 1, 6'h38, 0);
    check("mode_read", 24'h23, rd);
    xfer(0, 1, 6'h3f, 0);
    check("alias_read", 24'h23, rd);
    $display("mode finished");
  endtask
  task automatic t_test_reg;
    xfer(0, 0, 6'h03, 24'habcdef);
    check("refused", 1, refd);
    check("test_cfg", 0, test_config_o);
    xfer(0, 1, 6'h03, 0);
    check("test_read", 0, rd);
    $display("test register finished");
  endtask
  task automatic t_link_reset;
    int f;
    f = fr_cnt;
    xfer(1, 0, 6'h00, 0);
    check("full_reset", 1, fr_cnt - f);
    xfer(0, 1, 6'h01, 0);
    check("port", 24'h70, rd);
    xfer(0, 1, 6'h38, 0);
    check("mode_read", 0, rd);
    $display("link reset finished");
  endtask
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    rnw_i = 1'b0;
    reset_seq_i = 1'b0;
    addr_i = 6'h00;
    wdata_i = 24'h000000;
    second_gpio_i = 1'b1;
    data_unread_i = 8'h00;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_defaults();
    t_gpio();
    t_ready();
    t_mode();
    t_test_reg();
    t_link_reset();
    summarize();
  end
endmodule
